// ==== src/buffered_register_file_access.sv ====
// buffered/active control-register file with update and access arbitration
`timescale 1ns/1ps
module buffered_register_file_access (
  // clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   resetn_in,
  // serial control port byte access
  input  wire regfile_pkg::byte_req_t sp_req_in,
  output regfile_pkg::byte_rsp_t      sp_rsp_out,
  // eeprom controller byte access
  input  wire logic                   ee_active_in,
  input  wire regfile_pkg::byte_req_t ee_req_in,
  output regfile_pkg::byte_rsp_t      ee_rsp_out,
  // multifunction pin used as update input
  input  wire logic                   update_pin_en_in,
  input  wire logic                   update_pin_in,
  // device state seen through the read-only register
  input  wire logic [7:0]             status_in,
  // active values and the update busy flag to the internal functions
  output logic [63:0]                 irq_mask_out,
  output logic [15:0]                 step_size_out,
  output logic                        update_busy_out
);

  typedef struct packed {
    logic                     readback_buffered;
    logic                     update_req;
    logic [63:0]              mask_buf;
    logic [63:0]              mask_act;
    logic [15:0]              step_buf;
    logic [15:0]              step_act;
    logic                     c_pending;
    logic [4:0]               div_cnt;
    logic [7:0]               status_act;
    logic                     pin_meta;
    logic                     pin_sync;
    logic                     pin_prev;
    logic                     sp_pend;
    logic                     sp_req_late;
    logic                     sp_from_mem;
    logic [7:0]               sp_byte;
    logic                     ee_pend;
    logic                     ee_req_late;
    logic                     ee_from_mem;
    logic [7:0]               ee_byte;
    regfile_pkg::byte_rsp_t   sp_rsp;
    regfile_pkg::byte_rsp_t   ee_rsp;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [7:0] mem_rdata;
  logic       mem_we;
  logic [5:0] mem_addr;
  logic [7:0] mem_wdata;

  //////////////////////////////////////////////////////////////////////////
  // address decode and access classes

  function automatic regfile_pkg::reg_cls_t classify(input logic [15:0] a);
    regfile_pkg::reg_cls_t c;
    c = regfile_pkg::CLS_NONE;
    if (a == regfile_pkg::READBACK_ADDR || a == regfile_pkg::UPDATE_ADDR) begin
      c = regfile_pkg::CLS_LIVE_CTRL;
    end else if (a >= regfile_pkg::MASK_BASE && a <= regfile_pkg::MASK_LAST) begin
      c = regfile_pkg::CLS_MASK;
    end else if (a >= regfile_pkg::STEP_BASE && a <= regfile_pkg::STEP_LAST) begin
      c = regfile_pkg::CLS_STEP;
    end else if (a == regfile_pkg::STATUS_ADDR) begin
      c = regfile_pkg::CLS_STATUS;
    end else if (a >= regfile_pkg::SEQ_BASE && a <= regfile_pkg::ADDR_LAST) begin
      c = regfile_pkg::CLS_SEQ;
    end
    return c;
  endfunction

  // only the one class of the address is checked; with source, eeprom activity and direction it decides
  function automatic logic allowed(input regfile_pkg::reg_cls_t c,
                                   input logic from_ee,
                                   input logic ee_active,
                                   input logic is_wr);
    logic ok;
    ok = 1'b0;
    unique case (c)
      regfile_pkg::CLS_NONE: begin
        ok = 1'b0;
      end
      regfile_pkg::CLS_STATUS: begin
        ok = !is_wr && !from_ee;
      end
      regfile_pkg::CLS_LIVE_CTRL: begin
        ok = !from_ee && !ee_active;
      end
      default: begin
        ok = from_ee ? ee_active : !ee_active;
      end
    endcase
    return ok;
  endfunction

  // register byte other than the memory area
  function automatic logic [7:0] read_byte(input logic [15:0] a,
                                           input regfile_pkg::reg_cls_t c,
                                           input state_t s);
    logic [15:0] off;
    logic [63:0] m;
    logic [15:0] p;
    logic [7:0]  b;
    off = 16'h0000;
    m   = s.readback_buffered ? s.mask_buf : s.mask_act;
    p   = s.readback_buffered ? s.step_buf : s.step_act;
    b   = 8'h00;
    unique case (c)
      regfile_pkg::CLS_LIVE_CTRL: begin
        if (a == regfile_pkg::READBACK_ADDR) begin
          b = {7'h00, s.readback_buffered};
        end else begin
          b = {7'h00, s.update_req};
        end
      end
      regfile_pkg::CLS_MASK: begin
        off = a - regfile_pkg::MASK_BASE;
        b   = m[{off[2:0], 3'b000} +: 8];
      end
      regfile_pkg::CLS_STEP: begin
        off = a - regfile_pkg::STEP_BASE;
        b   = p[{off[0], 3'b000} +: 8];
      end
      regfile_pkg::CLS_STATUS: begin
        b = s.status_act;
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next state

  regfile_pkg::reg_cls_t sp_cls;
  regfile_pkg::reg_cls_t ee_cls;
  regfile_pkg::byte_req_t wr_req;
  regfile_pkg::reg_cls_t wr_cls;
  logic                   sp_rd_ok;
  logic                   ee_rd_ok;
  logic                   wr_ok;
  logic                   pin_edge;
  logic                   go;
  logic                   div_tick;
  logic [15:0]            wr_off;

  always_comb begin
    st_next = st_reg;
    wr_off  = 16'h0000;

    sp_cls = classify(sp_req_in.addr);
    ee_cls = classify(ee_req_in.addr);

    // only one source may write: the controller while active, else the port
    wr_req = ee_active_in ? ee_req_in : sp_req_in;
    wr_cls = ee_active_in ? ee_cls : sp_cls;
    wr_ok  = wr_req.wr && allowed(wr_cls, ee_active_in, ee_active_in, 1'b1);

    sp_rd_ok = sp_req_in.rd && allowed(sp_cls, 1'b0, ee_active_in, 1'b0);
    ee_rd_ok = ee_req_in.rd && allowed(ee_cls, 1'b1, ee_active_in, 1'b0);

    // the first stage feeds only the second
    st_next.pin_meta = update_pin_in;
    st_next.pin_sync = st_reg.pin_meta;
    st_next.pin_prev = st_reg.pin_sync;
    pin_edge = update_pin_en_in && st_reg.pin_sync && !st_reg.pin_prev;

    // free-running divider that paces the system-clock class
    st_next.div_cnt = (st_reg.div_cnt == regfile_pkg::DIV_LAST) ?
                      5'h00 : st_reg.div_cnt + 5'h01;
    div_tick = (st_reg.div_cnt == regfile_pkg::DIV_LAST);

    // a trigger that comes while the previous update is still pending is ignored, except an update-bit write in the cycle the update completes
    go = !st_reg.c_pending && (pin_edge || st_reg.update_req);

    if (go) begin
      st_next.mask_act   = st_reg.mask_buf;
      st_next.status_act = status_in;
      st_next.c_pending  = 1'b1;
    end

    if (st_reg.c_pending && div_tick) begin
      st_next.step_act   = st_reg.step_buf;
      st_next.c_pending  = 1'b0;
      st_next.update_req = 1'b0;
    end

    // writes land in buffered copies; live bits act at once
    if (wr_ok) begin
      unique case (wr_cls)
        regfile_pkg::CLS_LIVE_CTRL: begin
          if (wr_req.addr == regfile_pkg::READBACK_ADDR) begin
            st_next.readback_buffered =
              wr_req.wdata[regfile_pkg::READBACK_BIT];
          end else if (wr_req.wdata[regfile_pkg::UPDATE_BIT]) begin
            st_next.update_req = 1'b1;
          end
        end
        regfile_pkg::CLS_MASK: begin
          wr_off = wr_req.addr - regfile_pkg::MASK_BASE;
          st_next.mask_buf[{wr_off[2:0], 3'b000} +: 8] =
            wr_req.wdata;
        end
        regfile_pkg::CLS_STEP: begin
          wr_off = wr_req.addr - regfile_pkg::STEP_BASE;
          st_next.step_buf[{wr_off[0], 3'b000} +: 8] =
            wr_req.wdata;
        end
        default: begin
          st_next.readback_buffered = st_reg.readback_buffered;
        end
      endcase
    end

    // read pipeline: capture, then merge with the memory's registered data
    st_next.sp_pend     = sp_rd_ok;
    st_next.sp_from_mem = sp_rd_ok && sp_cls == regfile_pkg::CLS_SEQ;
    st_next.sp_byte     = sp_rd_ok ?
                          read_byte(sp_req_in.addr, sp_cls, st_reg) : 8'h00;
    st_next.ee_pend     = ee_rd_ok;
    st_next.ee_from_mem = ee_rd_ok && ee_cls == regfile_pkg::CLS_SEQ;
    st_next.ee_byte     = ee_rd_ok ?
                          read_byte(ee_req_in.addr, ee_cls, st_reg) : 8'h00;

    // a refused read still answers, with a zero byte
    st_next.sp_rsp.valid = st_reg.sp_pend || st_reg.sp_req_late;
    st_next.sp_rsp.data  = st_reg.sp_from_mem ? mem_rdata : st_reg.sp_byte;
    st_next.ee_rsp.valid = st_reg.ee_pend || st_reg.ee_req_late;
    st_next.ee_rsp.data  = st_reg.ee_from_mem ? mem_rdata : st_reg.ee_byte;
    st_next.sp_req_late  = sp_req_in.rd && !sp_rd_ok;
    st_next.ee_req_late  = ee_req_in.rd && !ee_rd_ok;
  end

  //////////////////////////////////////////////////////////////////////////
  // sequence area memory; bytes keep their own order, no value is assembled

  always_comb begin
    mem_addr  = 6'h00;
    mem_we    = wr_ok && wr_cls == regfile_pkg::CLS_SEQ;
    mem_wdata = wr_req.wdata;
    if (ee_active_in) begin
      mem_addr = 6'(ee_req_in.addr - regfile_pkg::SEQ_BASE);
    end else begin
      mem_addr = 6'(sp_req_in.addr - regfile_pkg::SEQ_BASE);
    end
  end

  seq_ram #(
    .WIDTH (regfile_pkg::DATA_W),
    .DEPTH (regfile_pkg::SEQ_DEPTH),
    .AW    (regfile_pkg::SEQ_AW)
  ) u_seq_ram (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .we_in       (mem_we),
    .addr_in     (mem_addr),
    .wdata_in    (mem_wdata),
    .rdata_out   (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg            <= '0;
      st_reg.mask_buf   <= regfile_pkg::MASK_RESET;
      st_reg.mask_act   <= regfile_pkg::MASK_RESET;
      st_reg.step_buf   <= regfile_pkg::STEP_RESET;
      st_reg.step_act   <= regfile_pkg::STEP_RESET;
      st_reg.status_act <= regfile_pkg::STATUS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sp_rsp_out      = st_reg.sp_rsp;
  assign ee_rsp_out      = st_reg.ee_rsp;
  assign irq_mask_out    = st_reg.mask_act;
  assign step_size_out   = st_reg.step_act;
  assign update_busy_out = st_reg.c_pending;

endmodule // buffered_register_file_access

// ==== src/regfile_pkg.sv ====
// shared constants and types of the buffered control-register file
package regfile_pkg;

  // address space, one byte per address
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam logic [15:0] ADDR_LAST     = 16'h0e3f;

  // live control registers
  localparam logic [15:0] READBACK_ADDR = 16'h0004;
  localparam int          READBACK_BIT  = 0;
  localparam logic [15:0] UPDATE_ADDR   = 16'h0005;
  localparam int          UPDATE_BIT    = 0;

  // buffered interrupt mask, serial-clock class, eight bytes
  localparam logic [15:0] MASK_BASE     = 16'h0209;
  localparam logic [15:0] MASK_LAST     = 16'h0210;
  localparam int          MASK_BYTES    = 8;
  localparam logic [63:0] MASK_RESET    = 64'h0000_0000_0000_0000;

  // buffered phase offset step size, system-clock class, two bytes
  localparam logic [15:0] STEP_BASE     = 16'h0314;
  localparam logic [15:0] STEP_LAST     = 16'h0315;
  localparam int          STEP_BYTES    = 2;
  localparam logic [15:0] STEP_RESET    = 16'h03e8;

  // read-only status snapshot
  localparam logic [15:0] STATUS_ADDR   = 16'h0d00;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  // storage sequence area, kept byte for byte
  localparam logic [15:0] SEQ_BASE      = 16'h0e10;
  localparam logic [15:0] SEQ_LAST      = 16'h0e3f;
  localparam int          SEQ_DEPTH     = 48;
  localparam int          SEQ_AW        = 6;

  // system clock divider for the system-clock update class
  localparam int          SYS_DIV       = 32;
  localparam int          DIV_W         = 5;
  localparam logic [4:0]  DIV_LAST      = 5'(SYS_DIV - 1);

  // one byte access from either access source
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } byte_req_t;

  // read answer to either source
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_rsp_t;

  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_LIVE_CTRL,
    CLS_MASK,
    CLS_STEP,
    CLS_STATUS,
    CLS_SEQ
  } reg_cls_t;

endpackage

// ==== src/seq_ram.sv ====
// byte memory for the storage sequence area, registered read data
`timescale 1ns/1ps
module seq_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 48,
  parameter int AW    = 6
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  // access port
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    addr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge core_clk_in) begin
    if (we_in) begin
      mem_reg[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_reg[addr_in];
    end
  end

endmodule // seq_ram

// ==== tb/regfile_checker.sv ====
// port assertions for the buffered register file
`timescale 1ns/1ps
module regfile_checker (
  // clock and reset
  input wire logic                   core_clk_in,
  input wire logic                   resetn_in,
  // watched ports
  input wire regfile_pkg::byte_req_t sp_req_in,
  input wire regfile_pkg::byte_rsp_t sp_rsp_out,
  input wire logic                   ee_active_in,
  input wire regfile_pkg::byte_req_t ee_req_in,
  input wire regfile_pkg::byte_rsp_t ee_rsp_out,
  input wire logic [63:0]            irq_mask_out,
  input wire logic [15:0]            step_size_out,
  input wire logic                   update_busy_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_sp_lat;
    sp_req_in.rd |-> ##2 sp_rsp_out.valid;
  endproperty
  a_sp_lat: assert property (p_sp_lat)
    else $error("port read answer missing");
  property p_no_spur;
    sp_rsp_out.valid |-> $past(sp_req_in.rd, 2);
  endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("port answer without read");
  property p_ee_lat;
    ee_req_in.rd |-> ##2 ee_rsp_out.valid;
  endproperty
  a_ee_lat: assert property (p_ee_lat)
    else $error("eeprom read answer missing");
  property p_unmapped;
    sp_req_in.rd && sp_req_in.addr > regfile_pkg::ADDR_LAST
      |-> ##2 sp_rsp_out.data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("missing address read not zero");
  property p_ee_deny;
    sp_req_in.rd && ee_active_in
      && sp_req_in.addr != regfile_pkg::STATUS_ADDR
      |-> ##2 sp_rsp_out.data == 8'h00;
  endproperty
  a_ee_deny: assert property (p_ee_deny)
    else $error("port read not refused while eeprom active");
  property p_ee_refused;
    ee_req_in.rd && !ee_active_in |-> ##2 ee_rsp_out.data == 8'h00;
  endproperty
  a_ee_refused: assert property (p_ee_refused)
    else $error("idle eeprom read not refused");
  property p_mask_hold;
    $changed(irq_mask_out) |-> update_busy_out;
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed outside an update");
  property p_step_hold;
    $changed(step_size_out) |-> $fell(update_busy_out);
  endproperty
  a_step_hold: assert property (p_step_hold)
    else $error("step changed off the divided clock");
  property p_busy_bound;
    $rose(update_busy_out) |-> ##[1:32] !update_busy_out;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("system class copy took too long");
endmodule // regfile_checker

bind buffered_register_file_access regfile_checker chk_i (
  .core_clk_in     (core_clk_in),
  .resetn_in       (resetn_in),
  .sp_req_in       (sp_req_in),
  .sp_rsp_out      (sp_rsp_out),
  .ee_active_in    (ee_active_in),
  .ee_req_in       (ee_req_in),
  .ee_rsp_out      (ee_rsp_out),
  .irq_mask_out    (irq_mask_out),
  .step_size_out   (step_size_out),
  .update_busy_out (update_busy_out)
);

// ==== tb/port_host.sv ====
// serial port host model issuing byte accesses
`timescale 1ns/1ps
module port_host (
  // clock
  input  wire logic              core_clk_in,
  // byte access toward the register file
  output regfile_pkg::byte_req_t req_out
);
  initial req_out = '0;
  // address is handed over already built high byte first
  task automatic acc(input logic w, r, input logic [15:0] a,
                     input logic [7:0] d, input int gap);
    repeat (gap) @(posedge core_clk_in);
    @(posedge core_clk_in);
    #1;
    req_out = '{w, r, a, d};
    @(posedge core_clk_in);
    #1;
    // released fields flip so a stale value never looks valid
    req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // port_host

// ==== tb/testbench.sv ====
// self-checking bench for the buffered register file
`timescale 1ns/1ps
module testbench;
  logic                   core_clk_in, resetn_in, ee_active_in;
  logic                   pin_en, pin;
  logic [7:0]             status_in, st, sd, sq[$], eq[$];
  regfile_pkg::byte_req_t sp_req, ee_req;
  regfile_pkg::byte_rsp_t sp_rsp, ee_rsp;
  logic [63:0]            irq_mask, mval;
  logic [15:0]            step, sval;
  logic                   busy;
  int                     num_errors, total_checks, cyc;
  initial begin
    core_clk_in = 0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  buffered_register_file_access DUT (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .sp_req_in(sp_req), .sp_rsp_out(sp_rsp),
    .ee_active_in(ee_active_in), .ee_req_in(ee_req),
    .ee_rsp_out(ee_rsp), .update_pin_en_in(pin_en),
    .update_pin_in(pin), .status_in(status_in),
    .irq_mask_out(irq_mask), .step_size_out(step),
    .update_busy_out(busy));
  port_host host (.core_clk_in(core_clk_in), .req_out(sp_req));
  task automatic chk(input string nm, input logic [63:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    sq.push_back(e);
    host.acc(1'b0, 1'b1, a, 8'h00, $urandom_range(2));
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.acc(1'b1, 1'b0, a, d, $urandom_range(2));
  endtask
  task automatic ea(input logic w, r, input logic [15:0] a,
                    input logic [7:0] d, e);
    if (r)
      eq.push_back(e);
    @(posedge core_clk_in);
    #1;
    ee_req = '{w, r, a, d};
    @(posedge core_clk_in);
    #1;
    ee_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // busy rises two edges after an update-bit write and three after a pin edge, then falls at the wrap
  task automatic wait_done;
    repeat (3) @(posedge core_clk_in);
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(posedge core_clk_in);
    #1;
  endtask
  task automatic results;
    chk("pending", 64'h0, 64'(sq.size() + eq.size()));
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge core_clk_in) begin
    if (sp_rsp.valid === 1'b1)
      chk("sp_data", sq.size() ? sq.pop_front() : 8'hxx, sp_rsp.data);
    if (ee_rsp.valid === 1'b1)
      chk("ee_data", eq.size() ? eq.pop_front() : 8'hxx, ee_rsp.data);
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    void'($urandom(32'ha8c1));
    resetn_in = 0;
    ee_active_in = 0;
    pin_en = 1;
    pin = 0;
    ee_req = '0;
    status_in = 8'($urandom);
    st = status_in;
    mval = {$urandom, $urandom};
    sval = 16'($urandom);
    sd = 8'($urandom);
    repeat (3) @(posedge core_clk_in);
    #1 resetn_in = 1;
    chk("step_rst", 64'h3e8, 64'(step));
    chk("mask_rst", 64'h0, irq_mask);
    rd(16'h0314, 8'he8);
    rd(16'h0315, 8'h03);
    for (int k = 0; k < 8; k++)
      wr(regfile_pkg::MASK_BASE + 16'(k), mval[8*k+:8]);
    wr(regfile_pkg::STEP_BASE, sval[7:0]);
    wr(regfile_pkg::STEP_BASE + 16'h1, sval[15:8]);
    chk("mask_held", 64'h0, irq_mask);
    rd(regfile_pkg::MASK_BASE, 8'h00);
    wr(regfile_pkg::READBACK_ADDR, 8'h01);
    for (int k = 0; k < 8; k++)
      rd(regfile_pkg::MASK_BASE + 16'(k), mval[8*k+:8]);
    wr(regfile_pkg::READBACK_ADDR, 8'h00);
    rd(regfile_pkg::STATUS_ADDR, regfile_pkg::STATUS_RESET);
    wr(regfile_pkg::UPDATE_ADDR, 8'h01);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("mask_upd", mval, irq_mask);
    wait_done();
    chk("step_upd", 64'(sval), 64'(step));
    rd(regfile_pkg::UPDATE_ADDR, 8'h00);
    wr(regfile_pkg::STATUS_ADDR, ~st);
    rd(regfile_pkg::STATUS_ADDR, st);
    status_in = ~st;
    pin = 1;
    repeat (4) @(posedge core_clk_in);
    #1 pin = 0;
    wait_done();
    rd(regfile_pkg::STATUS_ADDR, ~st);
    // pin not configured as update input: an edge must start nothing
    pin_en = 0;
    status_in = st;
    pin = 1;
    repeat (4) @(posedge core_clk_in);
    #1 pin = 0;
    chk("pin_off_busy", 64'h0, 64'(busy));
    wr(regfile_pkg::SEQ_BASE, sd);
    wr(regfile_pkg::SEQ_LAST, ~sd);
    rd(regfile_pkg::SEQ_BASE, sd);
    rd(regfile_pkg::SEQ_LAST, ~sd);
    wr(16'h0e40, 8'hff);
    rd(16'h0e40, 8'h00);
    rd(16'h0100, 8'h00);
    ee_active_in = 1;
    rd(regfile_pkg::STEP_BASE, 8'h00);
    wr(regfile_pkg::STEP_BASE, ~sval[7:0]);
    rd(regfile_pkg::STATUS_ADDR, ~st);
    ea(1'b0, 1'b1, regfile_pkg::STEP_BASE, 8'h00, sval[7:0]);
    ea(1'b1, 1'b0, regfile_pkg::SEQ_BASE + 16'h1, ~sd, 8'h00);
    ea(1'b0, 1'b1, regfile_pkg::SEQ_BASE + 16'h1, 8'h00, ~sd);
    ea(1'b0, 1'b1, regfile_pkg::UPDATE_ADDR, 8'h00, 8'h00);
    ea(1'b0, 1'b1, regfile_pkg::STATUS_ADDR, 8'h00, 8'h00);
    ea(1'b1, 1'b0, regfile_pkg::READBACK_ADDR, 8'h01, 8'h00);
    ee_active_in = 0;
    ea(1'b0, 1'b1, regfile_pkg::SEQ_BASE, 8'h00, 8'h00);
    rd(regfile_pkg::READBACK_ADDR, 8'h00);
    rd(regfile_pkg::STEP_BASE, sval[7:0]);
    rd(regfile_pkg::SEQ_BASE + 16'h1, ~sd);
    repeat (4) @(posedge core_clk_in);
    results();
  end
endmodule // testbench
